// [rtl/bwap_pkg.sv]
// Package of constants and types for the block window aperture port.
`default_nettype none
package bwap_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_WIN = 2;
    localparam int WIN_W = 1;
    localparam int LINE_BYTES = 64;
    localparam int LINE_SHIFT = 6;
    localparam int ADDR_W = 37;
    localparam int MAX_LINES = 128;
    localparam int MAX_BLOCK_BYTES = 8192;
    localparam int APER_OFF_W = 13;
    localparam int DATA_W = 64;
    localparam int LINE_IDX_W = 7;
    localparam int SIZE_W = 8;
    // ------------------------------------------------------------------
    // Command/address register fields
    // ------------------------------------------------------------------
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_SIZE_LSB = 48;
    localparam int CMD_DIR_BIT = 56;
    localparam logic [63:0] CMD_RESET = 64'h0;
    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int ST_INVALID_ADDR = 0;
    localparam int ST_MEDIA_UE = 1;
    localparam int ST_DIR_MISMATCH = 2;
    localparam int ST_LOCKED = 4;
    localparam int ST_DISABLED = 5;
    localparam int ST_PENDING = 31;
    localparam logic [31:0] ST_RESET = 32'h0;
    localparam logic [31:0] ST_ERR_MASK = 32'h0000_0037;
    localparam int MEM_WORDS = 1024;
    localparam int MEM_AW = 10;

    typedef struct packed {
        logic [ADDR_W-1:0] media_address;
        logic [SIZE_W-1:0] lines;
        logic write_dir;
    } bwap_cmd_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [WIN_W-1:0] window;
        logic [APER_OFF_W-1:0] offset;
        logic [DATA_W-1:0] wdata;
    } bwap_aper_req_type;

    typedef enum logic [2:0] {
        BWAP_IDLE = 3'b001,
        BWAP_BUSY = 3'b010,
        BWAP_DONE = 3'b100
    } bwap_state_type;
endpackage
`default_nettype wire

// [rtl/bwap_media_ram.sv]
// Small media store with registered read data.
`default_nettype none
module bwap_media_ram (
    // Clock
    input wire logic i_clock,
    input wire logic i_ce,
    // Access
    input wire logic i_we,
    input wire logic [bwap_pkg::MEM_AW-1:0] i_addr,
    input wire logic [bwap_pkg::DATA_W-1:0] i_wdata,
    output logic [bwap_pkg::DATA_W-1:0] o_rdata
);
    import bwap_pkg::*;
    logic [DATA_W-1:0] mem_r [MEM_WORDS];
    always_ff @(posedge i_clock) begin
        if (i_ce) begin
            if (i_we) begin
                mem_r[i_addr] <= i_wdata;
            end
            o_rdata <= mem_r[i_addr];
        end
    end
endmodule // bwap_media_ram
`default_nettype wire

// [rtl/bwap_port.sv]
// Block window aperture port: command, status and aperture per window.
`default_nettype none
module bwap_port (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_ce,
    // Configuration
    input wire logic i_buffered,
    input wire logic [bwap_pkg::ADDR_W-1:0] i_media_lines,
    input wire logic [bwap_pkg::NUM_WIN-1:0] i_window_disabled,
    input wire logic [bwap_pkg::ADDR_W-1:0] i_lock_base,
    input wire logic [bwap_pkg::ADDR_W-1:0] i_lock_limit,
    input wire logic i_lock_enable,
    input wire logic i_media_ue,
    // Command register writes and reads
    input wire logic i_cmd_we,
    input wire logic [bwap_pkg::WIN_W-1:0] i_cmd_window,
    input wire logic [63:0] i_cmd_wdata,
    output logic [63:0] o_cmd_rdata,
    // Status register read
    input wire logic [bwap_pkg::WIN_W-1:0] i_status_window,
    output logic [31:0] o_status,
    // Aperture access
    input wire bwap_pkg::bwap_aper_req_type i_aper,
    output logic o_aper_ready,
    output logic o_aper_rvalid,
    output logic [bwap_pkg::DATA_W-1:0] o_aper_rdata
);
    import bwap_pkg::*;

    // ------------------------------------------------------------------
    // Per-window registers and the shared read-pending flag
    // ------------------------------------------------------------------
    logic [63:0] cmd_r [NUM_WIN];
    logic [31:0] status_r [NUM_WIN];
    bwap_state_type state_r [NUM_WIN];
    logic rd_pend_r;

    // ------------------------------------------------------------------
    // Aperture decode
    // ------------------------------------------------------------------
    bwap_cmd_type cur_cmd;
    wire [63:0] aper_cmd = cmd_r[i_aper.window];
    wire [LINE_IDX_W-1:0] aper_line = i_aper.offset[APER_OFF_W-1:LINE_SHIFT];
    wire [ADDR_W-1:0] aper_media_line;
    wire aper_in_block;
    wire aper_last;
    wire err_invalid;
    wire err_locked;
    wire err_disabled;
    wire err_dir;
    wire aper_go;
    wire aper_ok;
    wire [SIZE_W-1:0] size_lim;

    assign cur_cmd.media_address = aper_cmd[CMD_ADDR_LSB +: ADDR_W];
    assign cur_cmd.lines = aper_cmd[CMD_SIZE_LSB +: SIZE_W];
    assign cur_cmd.write_dir = aper_cmd[CMD_DIR_BIT];
    assign size_lim = (cur_cmd.lines > SIZE_W'(MAX_LINES)) ? SIZE_W'(MAX_LINES)
                                                            : cur_cmd.lines;
    assign aper_media_line = cur_cmd.media_address + ADDR_W'(aper_line);
    assign aper_in_block = {1'b0, aper_line} < size_lim;
    assign aper_last = ({1'b0, aper_line} == size_lim - SIZE_W'(1))
                       && (i_aper.offset[LINE_SHIFT-1:0] == 6'h38);
    assign err_invalid = aper_media_line >= i_media_lines;
    assign err_locked = i_lock_enable && aper_media_line >= i_lock_base
                        && aper_media_line <= i_lock_limit;
    assign err_disabled = i_window_disabled[i_aper.window];
    assign err_dir = i_aper.write != cur_cmd.write_dir;
    assign aper_go = i_aper.valid && o_aper_ready && aper_in_block;
    assign aper_ok = aper_go && !err_invalid && !err_locked && !err_disabled && !err_dir;
    assign o_aper_ready = !i_cmd_we || (i_cmd_window != i_aper.window);

    // ------------------------------------------------------------------
    // Media store
    // ------------------------------------------------------------------
    // The model store keeps eight words for each of the low 128 media lines.
    // Higher media lines alias onto them, which is enough for a bench.
    wire [MEM_AW-1:0] mem_addr = {aper_media_line[MEM_AW-4:0],
                                  i_aper.offset[LINE_SHIFT-1:3]};
    logic [DATA_W-1:0] mem_rdata;

    bwap_media_ram u_ram (
        .i_clock(i_clock),
        .i_ce(i_ce),
        .i_we(aper_ok && i_aper.write),
        .i_addr(mem_addr),
        .i_wdata(i_aper.wdata),
        .o_rdata(mem_rdata)
    );

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rd_pend_r <= 1'b0;
            o_aper_rvalid <= 1'b0;
            o_aper_rdata <= 64'h0;
        end else if (i_ce) begin
            rd_pend_r <= aper_go && !i_aper.write;
            o_aper_rvalid <= rd_pend_r;
            o_aper_rdata <= mem_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Window state, one set per window
    // ------------------------------------------------------------------
    for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
        wire hit = aper_go && (i_aper.window == WIN_W'(w));
        wire cmd_hit = i_cmd_we && (i_cmd_window == WIN_W'(w));
        logic [31:0] err_set;
        logic [31:0] status_nxt;
        bwap_state_type state_nxt;
        always_comb begin
            err_set = 32'h0;
            if (hit) begin
                err_set[ST_INVALID_ADDR] = err_invalid;
                err_set[ST_MEDIA_UE] = i_media_ue && !err_invalid;
                err_set[ST_DIR_MISMATCH] = err_dir;
                err_set[ST_LOCKED] = err_locked;
                err_set[ST_DISABLED] = err_disabled;
            end
        end
        always_comb begin
            state_nxt = state_r[w];
            status_nxt = status_r[w] | err_set;
            case (state_r[w])
                BWAP_IDLE: begin
                    state_nxt = BWAP_IDLE;
                end
                BWAP_BUSY: begin
                    if (hit && aper_last) begin
                        state_nxt = BWAP_DONE;
                    end
                end
                BWAP_DONE: begin
                    state_nxt = BWAP_DONE;
                end
                default: begin
                    state_nxt = BWAP_IDLE;
                end
            endcase
            status_nxt[ST_PENDING] = i_buffered && (state_nxt == BWAP_BUSY);
            if (cmd_hit) begin
                status_nxt = ST_RESET;
                status_nxt[ST_PENDING] = i_buffered;
                state_nxt = BWAP_BUSY;
            end
        end
        always_ff @(posedge i_clock) begin
            if (i_srst) begin
                cmd_r[w] <= CMD_RESET;
                status_r[w] <= ST_RESET;
                state_r[w] <= BWAP_IDLE;
            end else if (i_ce) begin
                if (cmd_hit) begin
                    cmd_r[w] <= i_cmd_wdata;
                end
                status_r[w] <= status_nxt;
                state_r[w] <= state_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    assign o_cmd_rdata = cmd_r[i_cmd_window];
    assign o_status = status_r[i_status_window];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_clear_on_cmd;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_cmd_we) |=> ((status_r[$past(i_cmd_window)] & ST_ERR_MASK) == 32'h0);
    endproperty
    a_clear_on_cmd: assert property (p_clear_on_cmd) else $error("Status not cleared");

    property p_dir;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && err_dir && !i_cmd_we) |=> status_r[$past(i_aper.window)][ST_DIR_MISMATCH];
    endproperty
    a_dir: assert property (p_dir) else $error("Direction mismatch missed");

    property p_invalid;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && err_invalid && !i_cmd_we) |=> status_r[$past(i_aper.window)][ST_INVALID_ADDR];
    endproperty
    a_invalid: assert property (p_invalid) else $error("Invalid address missed");

    property p_ue;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && i_media_ue && !err_invalid && !i_cmd_we)
            |=> status_r[$past(i_aper.window)][ST_MEDIA_UE];
    endproperty
    a_ue: assert property (p_ue) else $error("Media error missed");

    property p_locked;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && err_locked && !i_cmd_we) |=> status_r[$past(i_aper.window)][ST_LOCKED];
    endproperty
    a_locked: assert property (p_locked) else $error("Locked range missed");

    property p_disabled;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && err_disabled && !i_cmd_we) |=> status_r[$past(i_aper.window)][ST_DISABLED];
    endproperty
    a_disabled: assert property (p_disabled) else $error("Disabled window missed");

    property p_pending;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_buffered) ##1 (state_r[0] == BWAP_BUSY) |-> status_r[0][ST_PENDING];
    endproperty
    a_pending: assert property (p_pending) else $error("Pending not held");

    property p_no_pend_done;
        @(posedge i_clock) disable iff (i_srst)
        (state_r[0] == BWAP_DONE) |-> !status_r[0][ST_PENDING];
    endproperty
    a_no_pend_done: assert property (p_no_pend_done) else $error("Pending after done");

    property p_reuse;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_cmd_we && i_cmd_window == 1'b0) |=> (state_r[0] == BWAP_BUSY);
    endproperty
    a_reuse: assert property (p_reuse) else $error("Window not reusable");

    property p_outside;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_aper.valid && !aper_in_block) |=> !rd_pend_r;
    endproperty
    a_outside: assert property (p_outside) else $error("Access past block size");

    property p_rvalid;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && !i_aper.write) ##1 i_ce |=> o_aper_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("Read data missing");

    // ------------------------------------------------------------------
    // Assertions on command, status and handshake
    // ------------------------------------------------------------------
    // The command word lands whole in the window that was addressed.
    property p_cmd_store;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_cmd_we) |=> (cmd_r[$past(i_cmd_window)] == $past(i_cmd_wdata));
    endproperty
    a_cmd_store: assert property (p_cmd_store) else $error("Command word not stored");

    // A fresh command starts with pending equal to the buffered flag.
    property p_pend_start;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_cmd_we)
            |=> (status_r[$past(i_cmd_window)][ST_PENDING] == $past(i_buffered));
    endproperty
    a_pend_start: assert property (p_pend_start) else $error("Pending start wrong");

    // Error flags stay set until that window's command is written again.
    property p_sticky;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && !(i_cmd_we && i_cmd_window == 1'b0))
            |=> ((status_r[0] & $past(status_r[0]) & ST_ERR_MASK)
                 == ($past(status_r[0]) & ST_ERR_MASK));
    endproperty
    a_sticky: assert property (p_sticky) else $error("Error flag lost");

    // A command to one window leaves the error flags of the other alone.
    property p_other_window;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_cmd_we && i_cmd_window == 1'b1 && !aper_go)
            |=> ((status_r[0] & ST_ERR_MASK) == ($past(status_r[0]) & ST_ERR_MASK));
    endproperty
    a_other_window: assert property (p_other_window) else $error("Window crosstalk");

    // Reserved status bits read as zero in both windows.
    property p_reserved;
        @(posedge i_clock) disable iff (i_srst)
        (((status_r[0] | status_r[1]) & ~(ST_ERR_MASK | (32'h1 << ST_PENDING))) == 32'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved status bit set");

    // The aperture only stalls for a command write to its own window.
    property p_ready_free;
        @(posedge i_clock) disable iff (i_srst)
        (!i_cmd_we || i_cmd_window != i_aper.window) |-> o_aper_ready;
    endproperty
    a_ready_free: assert property (p_ready_free) else $error("Aperture stalled");

    property p_ready_block;
        @(posedge i_clock) disable iff (i_srst)
        (i_cmd_we && i_cmd_window == i_aper.window) |-> !o_aper_ready;
    endproperty
    a_ready_block: assert property (p_ready_block) else $error("Aperture raced");

    // Reaching the last word of the block ends the transfer.
    property p_done_last;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && aper_go && aper_last && i_aper.window == 1'b0 && state_r[0] == BWAP_BUSY)
            |=> (state_r[0] == BWAP_DONE);
    endproperty
    a_done_last: assert property (p_done_last) else $error("Transfer did not end");

    property p_idle_no_pend;
        @(posedge i_clock) disable iff (i_srst)
        (state_r[0] == BWAP_IDLE) |-> !status_r[0][ST_PENDING];
    endproperty
    a_idle_no_pend: assert property (p_idle_no_pend) else $error("Idle pending");

    // The second window keeps its pending flag for as long as it is busy.
    property p_pending_w1;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && i_buffered) ##1 (state_r[1] == BWAP_BUSY) |-> status_r[1][ST_PENDING];
    endproperty
    a_pending_w1: assert property (p_pending_w1) else $error("Pending not held");

    // Read data only appear after an accepted read.
    property p_rvalid_only;
        @(posedge i_clock) disable iff (i_srst)
        (i_ce && !rd_pend_r) |=> !o_aper_rvalid;
    endproperty
    a_rvalid_only: assert property (p_rvalid_only) else $error("Spurious read data");

    c_write: cover property (@(posedge i_clock) aper_ok && i_aper.write);
    c_read: cover property (@(posedge i_clock) o_aper_rvalid);
    c_done: cover property (@(posedge i_clock) state_r[0] == BWAP_DONE);
    c_err: cover property (@(posedge i_clock) (status_r[0] & ST_ERR_MASK) != 32'h0);
    c_pending: cover property (@(posedge i_clock) status_r[1][ST_PENDING]);
endmodule // bwap_port
`default_nettype wire

// [test/bwap_host.sv]
// Host driver model that programs windows, moves aperture words and polls status.
`default_nettype none
module bwap_host (
    // Clock
    input wire logic i_clock,
    // Requests
    output var logic o_cmd_we,
    output var logic [bwap_pkg::WIN_W-1:0] o_cmd_window,
    output var logic [63:0] o_cmd_wdata,
    output var logic [bwap_pkg::WIN_W-1:0] o_status_window,
    output var bwap_pkg::bwap_aper_req_type o_aper,
    // Answers
    input wire logic [31:0] i_status,
    input wire logic i_aper_ready,
    input wire logic i_aper_rvalid,
    input wire logic [bwap_pkg::DATA_W-1:0] i_aper_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import bwap_pkg::*;
    // Flat offsets, no caches and no direct mapping in this model.
    initial begin
        o_cmd_we = 1'b0;
        o_cmd_window = '0;
        o_cmd_wdata = '0;
        o_status_window = '0;
        o_aper = '0;
    end
    task automatic cmd(input logic [WIN_W-1:0] win, input logic [36:0] addr,
                       input logic [7:0] lines, input logic wr);
        @(posedge i_clock);
        #1;
        o_cmd_we = 1'b1;
        o_cmd_window = win;
        o_cmd_wdata = {7'h0, wr, lines, 11'h0, addr};
        @(posedge i_clock);
        #1;
        o_cmd_we = 1'b0;
        o_cmd_wdata = ~o_cmd_wdata;
    endtask
    task automatic aper(input logic [WIN_W-1:0] win, input logic wr, input logic [12:0] off,
                        input logic [63:0] wd, output logic got, output logic [63:0] rd);
        int n;
        @(posedge i_clock);
        #1;
        o_aper = '{valid: 1'b1, write: wr, window: win, offset: off, wdata: wd};
        @(posedge i_clock);
        for (n = 0; n < 8 && i_aper_ready !== 1'b1; n++) begin
            @(posedge i_clock);
        end
        #1;
        o_aper.valid = 1'b0;
        o_aper.wdata = ~wd;
        got = 1'b0;
        rd = '0;
        for (n = 0; n < 4 && !wr && !got; n++) begin
            @(posedge i_clock);
            #1;
            got = (i_aper_rvalid === 1'b1);
            rd = i_aper_rdata;
        end
    endtask
    task automatic status(input logic [WIN_W-1:0] win, input logic wait_done,
                          output logic [31:0] st);
        int n;
        @(posedge i_clock);
        #1;
        o_status_window = win;
        @(posedge i_clock);
        #1;
        st = i_status & (ST_ERR_MASK | 32'h8000_0000);
        for (n = 0; n < 300 && wait_done && st[ST_PENDING] !== 1'b0; n++) begin
            @(posedge i_clock);
            #1;
            st = i_status & (ST_ERR_MASK | 32'h8000_0000);
        end
    endtask
endmodule // bwap_host
`default_nettype wire

// [test/tb.sv]
// Self-checking testbench for the block window aperture port.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import bwap_pkg::*;
    logic clock, srst, ce, buffered, lock_enable, media_ue, cmd_we, ready, rvalid, got;
    logic [ADDR_W-1:0] media_lines, lock_base, lock_limit;
    logic [NUM_WIN-1:0] window_disabled;
    logic [WIN_W-1:0] cmd_window, status_window;
    logic [63:0] cmd_wdata, cmd_rdata, rdata, rd;
    logic [31:0] status, st;
    bwap_aper_req_type aper;
    int errors = 0;
    int n_compared = 0;
    int bits[4] = '{ST_INVALID_ADDR, ST_MEDIA_UE, ST_LOCKED, ST_DISABLED};
    bwap_port i_dut (
        .i_clock(clock), .i_srst(srst), .i_ce(ce), .i_buffered(buffered),
        .i_media_lines(media_lines), .i_window_disabled(window_disabled),
        .i_lock_base(lock_base), .i_lock_limit(lock_limit), .i_lock_enable(lock_enable),
        .i_media_ue(media_ue), .i_cmd_we(cmd_we), .i_cmd_window(cmd_window),
        .i_cmd_wdata(cmd_wdata), .o_cmd_rdata(cmd_rdata), .i_status_window(status_window),
        .o_status(status), .i_aper(aper), .o_aper_ready(ready), .o_aper_rvalid(rvalid),
        .o_aper_rdata(rdata)
    );
    bwap_host i_host (
        .i_clock(clock), .o_cmd_we(cmd_we), .o_cmd_window(cmd_window),
        .o_cmd_wdata(cmd_wdata), .o_status_window(status_window), .o_aper(aper),
        .i_status(status), .i_aper_ready(ready), .i_aper_rvalid(rvalid), .i_aper_rdata(rdata)
    );
    // ------------------------------------------------------------------
    // Checks and closing
    // ------------------------------------------------------------------
    function automatic logic [63:0] pat(input int i);
        return {48'hbeef_0000_0000, 16'(i)};
    endfunction
    task automatic chk64(input string name, input logic [63:0] exp, input logic [63:0] seen);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #50us;
        errors++;
        end_sim();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        buffered = 1'b0;
        media_lines = 37'h400;
        window_disabled = 2'h0;
        lock_base = 37'h10;
        lock_limit = 37'h18;
        lock_enable = 1'b0;
        media_ue = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        srst = 1'b0;
        chk64("command reset", CMD_RESET, cmd_rdata);
        for (int w = 0; w < NUM_WIN; w++) begin
            i_host.status(WIN_W'(w), 1'b0, st);
            chk32("status reset", ST_RESET, st);
        end
        i_host.cmd(1'b0, 37'h5, 8'h2, 1'b1);
        chk64("command", {7'h0, 1'b1, 8'h2, 11'h0, 37'h5}, cmd_rdata);
        for (int i = 0; i < 16; i++) begin
            i_host.aper(1'b0, 1'b1, 13'(i * 8), pat(i), got, rd);
        end
        i_host.cmd(1'b0, 37'h5, 8'h2, 1'b0);
        i_host.status(1'b0, 1'b0, st);
        chk32("status after block write", 32'h0, st);
        for (int i = 0; i < 16; i++) begin
            i_host.aper(1'b0, 1'b0, 13'(i * 8), '0, got, rd);
            chk64("aperture data", pat(i), rd);
            chk64("read valid", 64'h1, {63'h0, got});
        end
        i_host.aper(1'b0, 1'b0, 13'h80, '0, got, rd);
        chk64("read beyond size", 64'h0, {63'h0, got});
        i_host.cmd(1'b0, 37'h0, 8'h80, 1'b1);
        i_host.aper(1'b0, 1'b1, 13'h1ff8, pat(99), got, rd);
        i_host.cmd(1'b0, 37'h0, 8'h80, 1'b0);
        i_host.aper(1'b0, 1'b0, 13'h1ff8, '0, got, rd);
        chk64("last aperture word", pat(99), rd);
        i_host.cmd(1'b1, 37'h5, 8'h1, 1'b0);
        i_host.aper(1'b1, 1'b1, 13'h0, pat(7), got, rd);
        i_host.status(1'b1, 1'b0, st);
        chk32("direction status", 32'h1 << ST_DIR_MISMATCH, st);
        i_host.cmd(1'b1, 37'h5, 8'h1, 1'b0);
        i_host.aper(1'b1, 1'b0, 13'h0, '0, got, rd);
        i_host.status(1'b1, 1'b0, st);
        chk32("status after reuse", 32'h0, st);
        for (int k = 0; k < 4; k++) begin
            media_lines = (k == 0) ? 37'h10 : 37'h400;
            media_ue = (k == 1);
            lock_enable = (k == 2);
            window_disabled = (k == 3) ? 2'h1 : 2'h0;
            i_host.cmd(1'b0, 37'h14, 8'h1, 1'b0);
            i_host.aper(1'b0, 1'b0, 13'h8, '0, got, rd);
            i_host.status(1'b0, 1'b0, st);
            chk32("error status", 32'h1 << bits[k], st);
            i_host.status(1'b1, 1'b0, st);
            chk32("other window status", 32'h0, st);
        end
        media_lines = 37'h400;
        media_ue = 1'b0;
        lock_enable = 1'b0;
        window_disabled = 2'h0;
        buffered = 1'b1;
        i_host.cmd(1'b1, 37'h5, 8'h1, 1'b0);
        i_host.status(1'b1, 1'b0, st);
        chk32("pending status", 32'h1 << ST_PENDING, st);
        i_host.aper(1'b1, 1'b0, 13'h38, '0, got, rd);
        i_host.status(1'b1, 1'b1, st);
        chk32("status after completion", 32'h0, st);
        i_host.cmd(1'b1, 37'h0, 8'hff, 1'b0);
        i_host.aper(1'b1, 1'b0, 13'h1ff8, '0, got, rd);
        chk64("clamped block data", pat(99), rd);
        i_host.status(1'b1, 1'b1, st);
        chk32("clamped block status", 32'h0, st);
        end_sim();
    end
endmodule // tb
`default_nettype wire
